// *** rtl/i2pg_pkg.sv ***
// ****************************************************************
// register map and field layout
// ****************************************************************
package i2pg_pkg;

   // word-aligned byte offsets on the bus
   localparam int unsigned ADR_W = 6;
   localparam logic [5:0] OFS_RECEIVE_DATA = 6'h00;
   localparam logic [5:0] OFS_TRANSMIT_DATA = 6'h04;
   localparam logic [5:0] OFS_BAUD_RELOAD = 6'h08;
   localparam logic [5:0] OFS_CONTROL_MAIN = 6'h0C;
   localparam logic [5:0] OFS_BUS_STATUS = 6'h10;
   localparam logic [5:0] OFS_OWN_ADDRESS = 6'h14;
   localparam logic [5:0] OFS_ADDRESS_MASK = 6'h18;
   localparam logic [5:0] OFS_CONTROL_LOW = 6'h1C;
   localparam logic [5:0] OFS_CONTROL_HIGH = 6'h20;
   localparam logic [5:0] OFS_PERIPH_DISABLE = 6'h24;

   // implemented bits, everything else reads zero
   localparam logic [15:0] MASK_RECEIVE_DATA = 16'h00FF;
   localparam logic [15:0] MASK_TRANSMIT_DATA = 16'h00FF;
   localparam logic [15:0] MASK_BAUD_RELOAD = 16'h01FF;
   localparam logic [15:0] MASK_CONTROL_MAIN = 16'hBFFF;
   localparam logic [15:0] MASK_BUS_STATUS = 16'hE7FF;
   localparam logic [15:0] MASK_OWN_ADDRESS = 16'h03FF;
   localparam logic [15:0] MASK_ADDRESS_MASK = 16'h03FF;
   localparam logic [15:0] MASK_CONTROL_HIGH = 16'h007F;
   localparam logic [15:0] MASK_PERIPH_DISABLE = 16'h0001;
   // status bits that software may clear by writing zero
   localparam logic [15:0] MASK_STATUS_SWCLR = 16'h0040;

   // field positions
   localparam int unsigned CON_ENABLE_BIT = 15;
   localparam int unsigned CON_STOP_IN_CPU_IDLE_BIT = 13;
   localparam int unsigned STAT_OVERFLOW_BIT = 6;
   localparam int unsigned STAT_STOP_BIT = 4;
   localparam int unsigned STAT_START_BIT = 3;
   localparam int unsigned STAT_RX_FULL_BIT = 1;
   localparam int unsigned PMD_MODULE_DISABLE_BIT = 0;

   // reset values
   localparam logic [15:0] RST_RECEIVE_DATA = 16'h0000;
   localparam logic [15:0] RST_TRANSMIT_DATA = 16'h0000;
   localparam logic [15:0] RST_BAUD_RELOAD = 16'h0000;
   localparam logic [15:0] RST_CONTROL_MAIN = 16'h0000;
   localparam logic [15:0] RST_BUS_STATUS = 16'h0000;
   localparam logic [15:0] RST_OWN_ADDRESS = 16'h0000;
   localparam logic [15:0] RST_ADDRESS_MASK = 16'h0000;
   localparam logic [15:0] RST_CONTROL_HIGH = 16'h0000;
   localparam logic [15:0] RST_PERIPH_DISABLE = 16'h0000;

   // bits per address byte seen on the serial bus
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // power state, one-hot
   typedef enum logic [2:0] {
      PS_RUN = 3'h1,
      PS_SAVE = 3'h2,
      PS_OFF = 3'h4
   } i2pg_pstate_t;

endpackage : i2pg_pkg

// *** rtl/i2pg_addr_sniff.sv ***
`timescale 1ns/1ps
// ****************************************************************
// address sniffer, shifts on the bus clock rising edges
// ****************************************************************
module i2pg_addr_sniff (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic run,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic [6:0] ownAddr,
   input wire logic [6:0] addrMask,
   output logic startSeen,
   output logic stopSeen,
   output logic matchHit,
   output logic [7:0] rxByte
);
   logic [1:0] sclSync_ff;
   logic [1:0] sdaSync_ff;
   logic sclDly_ff;
   logic sdaDly_ff;
   logic inFrame_ff;
   logic [3:0] bitCnt_ff;
   logic [7:0] shift_ff;
   logic sclRise;
   logic startEv;
   logic stopEv;

   // two flops per pin; only stage 1 feeds any logic
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sclSync_ff <= 2'h3;
         sdaSync_ff <= 2'h3;
         sclDly_ff <= 1'b1;
         sdaDly_ff <= 1'b1;
      end else begin
         sclSync_ff <= {sclSync_ff[0], sclIn};
         sdaSync_ff <= {sdaSync_ff[0], sdaIn};
         sclDly_ff <= sclSync_ff[1];
         sdaDly_ff <= sdaSync_ff[1];
      end
   end

   // start and stop are data edges while the clock is high
   assign sclRise = sclSync_ff[1] & ~sclDly_ff;
   assign startEv = sclSync_ff[1] & sclDly_ff & sdaDly_ff & ~sdaSync_ff[1];
   assign stopEv = sclSync_ff[1] & sclDly_ff & ~sdaDly_ff & sdaSync_ff[1];

   // only the first byte after a start is compared
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         inFrame_ff <= 1'b0;
         bitCnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         matchHit <= 1'b0;
         startSeen <= 1'b0;
         stopSeen <= 1'b0;
         rxByte <= 8'h00;
      end else if (!run) begin
         inFrame_ff <= 1'b0;
         bitCnt_ff <= 4'h0;
         matchHit <= 1'b0;
         startSeen <= 1'b0;
         stopSeen <= 1'b0;
      end else begin
         matchHit <= 1'b0;
         startSeen <= startEv;
         stopSeen <= stopEv;
         if (startEv) begin
            inFrame_ff <= 1'b1;
            bitCnt_ff <= 4'h0;
         end else if (stopEv) begin
            inFrame_ff <= 1'b0;
         end else if (inFrame_ff && sclRise) begin
            shift_ff <= {shift_ff[6:0], sdaSync_ff[1]};
            bitCnt_ff <= bitCnt_ff + 4'h1;
            if (bitCnt_ff == i2pg_pkg::BITS_PER_BYTE - 4'h1) begin
               inFrame_ff <= 1'b0;
               rxByte <= {shift_ff[6:0], sdaSync_ff[1]};
               // masked bits are don't-care in the compare
               matchHit <= ((shift_ff[6:0] ^ ownAddr) & ~addrMask) == 7'h00;
            end
         end
      end
   end
endmodule : i2pg_addr_sniff

// *** rtl/i2pg_regmap.sv ***
`timescale 1ns/1ps
// Operation
// - Cpu idle with stop_in_cpu_idle set gives a sleep-like save state.
// - Cpu idle with stop_in_cpu_idle clear leaves the controller running.
// - Setting module_disable_bit stops every clock feeding the controller.
// - While disabled, register writes are dropped and reads are not valid.
// - The controller runs only while module_disable_bit is clear.
// - Reset disables the controller, ends bus traffic, restores registers.
// - Unimplemented register bits read as zero.
// - Entering or leaving a save state leaves register contents untouched.
// - Saving, the slave shifts on the bus clock and wakes on address match.
module i2pg_regmap (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [i2pg_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic cpuIdle,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic ctrlClkRun,
   output logic powerSave,
   output logic engineEnable,
   output logic wakeReq
);

   // ****************************************************************
   // helpers
   // ****************************************************************

   // merge the two low byte lanes into a 16-bit register
   function automatic logic [15:0] laneMerge(
      input logic [15:0] old,
      input logic [31:0] wdat,
      input logic [3:0] sel,
      input logic [15:0] impl
   );
      logic [15:0] res;
      res = old;
      if (sel[0]) begin
         res[7:0] = wdat[7:0];
      end
      if (sel[1]) begin
         res[15:8] = wdat[15:8];
      end
      laneMerge = res & impl;
   endfunction : laneMerge

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [15:0] receiveData_ff;
   logic [15:0] transmitData_ff;
   logic [15:0] baudReload_ff;
   logic [15:0] controlMain_ff;
   logic [15:0] busStatus_ff;
   logic [15:0] ownAddress_ff;
   logic [15:0] addressMask_ff;
   logic [15:0] controlHigh_ff;
   logic [15:0] periphDisable_ff;
   i2pg_pkg::i2pg_pstate_t pstate_ff;
   i2pg_pkg::i2pg_pstate_t nxt_pstate;
   logic [15:0] nxt_busStatus;
   logic [15:0] rdWord;
   logic busReq;
   logic busWr;
   logic busRd;
   logic moduleOff;
   logic modWr;
   logic idleStop;
   logic startSeen;
   logic stopSeen;
   logic matchHit;
   logic [7:0] rxByte;

   // ****************************************************************
   // bus slave
   // ****************************************************************

   // the write and read side effects land on the ack edge, when the
   // master is known to sample; one wait state keeps data registered
   assign busReq = wb_cyc_i & wb_stb_i;
   assign busWr = busReq & wb_we_i & wb_ack_o;
   assign busRd = busReq & ~wb_we_i & wb_ack_o;

   assign moduleOff = periphDisable_ff[i2pg_pkg::PMD_MODULE_DISABLE_BIT];
   assign modWr = busWr & ~moduleOff;

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= busReq & ~wb_ack_o;
      end
   end

   // read multiplexer; unmapped offsets answer with zero
   always_comb begin
      rdWord = 16'h0000;
      unique case (wb_adr_i)
         i2pg_pkg::OFS_RECEIVE_DATA: rdWord = receiveData_ff;
         i2pg_pkg::OFS_TRANSMIT_DATA: rdWord = transmitData_ff;
         i2pg_pkg::OFS_BAUD_RELOAD: rdWord = baudReload_ff;
         i2pg_pkg::OFS_CONTROL_MAIN: rdWord = controlMain_ff;
         i2pg_pkg::OFS_CONTROL_LOW: rdWord = controlMain_ff;
         i2pg_pkg::OFS_BUS_STATUS: rdWord = busStatus_ff;
         i2pg_pkg::OFS_OWN_ADDRESS: rdWord = ownAddress_ff;
         i2pg_pkg::OFS_ADDRESS_MASK: rdWord = addressMask_ff;
         i2pg_pkg::OFS_CONTROL_HIGH: rdWord = controlHigh_ff;
         default: rdWord = 16'h0000;
      endcase
      // gated registers give a clean zero rather than stale data
      if (moduleOff) begin
         rdWord = 16'h0000;
      end
      // the disable register lives outside the gated clock domain
      if (wb_adr_i == i2pg_pkg::OFS_PERIPH_DISABLE) begin
         rdWord = periphDisable_ff;
      end
   end

   // read data captured on the request cycle, upper half zero
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (busReq && !wb_ack_o && !wb_we_i) begin
         wb_dat_o <= {16'h0000, rdWord};
      end else if (!busReq) begin
         wb_dat_o <= 32'h0000_0000;
      end
   end

   // ****************************************************************
   // peripheral disable register
   // ****************************************************************

   // always writable, so software can bring the module back
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         periphDisable_ff <= i2pg_pkg::RST_PERIPH_DISABLE;
      end else if (busWr && wb_adr_i == i2pg_pkg::OFS_PERIPH_DISABLE) begin
         periphDisable_ff <= laneMerge(periphDisable_ff, wb_dat_i, wb_sel_i,
                                       i2pg_pkg::MASK_PERIPH_DISABLE);
      end
   end

   // ****************************************************************
   // software registers
   // ****************************************************************

   // plain storage; the power state never touches these
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         transmitData_ff <= i2pg_pkg::RST_TRANSMIT_DATA;
         baudReload_ff <= i2pg_pkg::RST_BAUD_RELOAD;
         ownAddress_ff <= i2pg_pkg::RST_OWN_ADDRESS;
         addressMask_ff <= i2pg_pkg::RST_ADDRESS_MASK;
         controlHigh_ff <= i2pg_pkg::RST_CONTROL_HIGH;
      end else if (modWr) begin
         unique case (wb_adr_i)
            i2pg_pkg::OFS_TRANSMIT_DATA: begin
               transmitData_ff <= laneMerge(transmitData_ff, wb_dat_i,
                  wb_sel_i, i2pg_pkg::MASK_TRANSMIT_DATA);
            end
            i2pg_pkg::OFS_BAUD_RELOAD: begin
               baudReload_ff <= laneMerge(baudReload_ff, wb_dat_i,
                  wb_sel_i, i2pg_pkg::MASK_BAUD_RELOAD);
            end
            i2pg_pkg::OFS_OWN_ADDRESS: begin
               ownAddress_ff <= laneMerge(ownAddress_ff, wb_dat_i,
                  wb_sel_i, i2pg_pkg::MASK_OWN_ADDRESS);
            end
            i2pg_pkg::OFS_ADDRESS_MASK: begin
               addressMask_ff <= laneMerge(addressMask_ff, wb_dat_i,
                  wb_sel_i, i2pg_pkg::MASK_ADDRESS_MASK);
            end
            i2pg_pkg::OFS_CONTROL_HIGH: begin
               controlHigh_ff <= laneMerge(controlHigh_ff, wb_dat_i,
                  wb_sel_i, i2pg_pkg::MASK_CONTROL_HIGH);
            end
            default: begin
               transmitData_ff <= transmitData_ff;
            end
         endcase
      end
   end

   // control word, reachable at two offsets with one storage
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         controlMain_ff <= i2pg_pkg::RST_CONTROL_MAIN;
      end else if (modWr && (wb_adr_i == i2pg_pkg::OFS_CONTROL_MAIN ||
                             wb_adr_i == i2pg_pkg::OFS_CONTROL_LOW)) begin
         controlMain_ff <= laneMerge(controlMain_ff, wb_dat_i, wb_sel_i,
                                     i2pg_pkg::MASK_CONTROL_MAIN);
      end
   end

   // ****************************************************************
   // address sniffer and receive path
   // ****************************************************************

   // kept running in the save state, the bus master supplies the clock
   i2pg_addr_sniff u_sniff (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .run(~moduleOff),
      .sclIn(sclIn),
      .sdaIn(sdaIn),
      .ownAddr(ownAddress_ff[6:0]),
      .addrMask(addressMask_ff[6:0]),
      .startSeen(startSeen),
      .stopSeen(stopSeen),
      .matchHit(matchHit),
      .rxByte(rxByte)
   );

   // receive register only loads on a matching address
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         receiveData_ff <= i2pg_pkg::RST_RECEIVE_DATA;
      end else if (matchHit) begin
         receiveData_ff <= {8'h00, rxByte} & i2pg_pkg::MASK_RECEIVE_DATA;
      end
   end

   // ****************************************************************
   // bus status
   // ****************************************************************

   // hardware sets win over a software clear in the same cycle
   always_comb begin
      nxt_busStatus = busStatus_ff;
      if (modWr && wb_adr_i == i2pg_pkg::OFS_BUS_STATUS && wb_sel_i[0]) begin
         nxt_busStatus = busStatus_ff &
            ~(i2pg_pkg::MASK_STATUS_SWCLR & ~{16'h0000 | wb_dat_i[15:0]});
      end
      if (busRd && !moduleOff && wb_adr_i == i2pg_pkg::OFS_RECEIVE_DATA) begin
         nxt_busStatus[i2pg_pkg::STAT_RX_FULL_BIT] = 1'b0;
      end
      if (startSeen) begin
         nxt_busStatus[i2pg_pkg::STAT_START_BIT] = 1'b1;
         nxt_busStatus[i2pg_pkg::STAT_STOP_BIT] = 1'b0;
      end
      if (stopSeen) begin
         nxt_busStatus[i2pg_pkg::STAT_STOP_BIT] = 1'b1;
         nxt_busStatus[i2pg_pkg::STAT_START_BIT] = 1'b0;
      end
      if (matchHit) begin
         // an unread byte being overwritten flags overflow
         if (busStatus_ff[i2pg_pkg::STAT_RX_FULL_BIT]) begin
            nxt_busStatus[i2pg_pkg::STAT_OVERFLOW_BIT] = 1'b1;
         end
         nxt_busStatus[i2pg_pkg::STAT_RX_FULL_BIT] = 1'b1;
      end
      nxt_busStatus = nxt_busStatus & i2pg_pkg::MASK_BUS_STATUS;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         busStatus_ff <= i2pg_pkg::RST_BUS_STATUS;
      end else begin
         busStatus_ff <= nxt_busStatus;
      end
   end

   // ****************************************************************
   // power state
   // ****************************************************************

   assign idleStop = cpuIdle &
      controlMain_ff[i2pg_pkg::CON_STOP_IN_CPU_IDLE_BIT];

   // disable beats idle; idle with the stop bit clear keeps running
   always_comb begin
      nxt_pstate = pstate_ff;
      unique case (pstate_ff)
         i2pg_pkg::PS_RUN: begin
            if (moduleOff) begin
               nxt_pstate = i2pg_pkg::PS_OFF;
            end else if (idleStop) begin
               nxt_pstate = i2pg_pkg::PS_SAVE;
            end
         end
         i2pg_pkg::PS_SAVE: begin
            if (moduleOff) begin
               nxt_pstate = i2pg_pkg::PS_OFF;
            end else if (!idleStop) begin
               nxt_pstate = i2pg_pkg::PS_RUN;
            end
         end
         i2pg_pkg::PS_OFF: begin
            if (!moduleOff) begin
               nxt_pstate = i2pg_pkg::PS_RUN;
            end
         end
         default: begin
            nxt_pstate = i2pg_pkg::PS_OFF;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pstate_ff <= i2pg_pkg::PS_RUN;
      end else begin
         pstate_ff <= nxt_pstate;
      end
   end

   // outputs follow the next state so they line up with it
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrlClkRun <= 1'b1;
         powerSave <= 1'b0;
         engineEnable <= 1'b0;
      end else begin
         ctrlClkRun <= nxt_pstate != i2pg_pkg::PS_OFF;
         powerSave <= nxt_pstate == i2pg_pkg::PS_SAVE;
         // the engine needs both the enable bit and the run state
         engineEnable <= (nxt_pstate == i2pg_pkg::PS_RUN) &
            controlMain_ff[i2pg_pkg::CON_ENABLE_BIT];
      end
   end

   // wake pulse only matters while the controller is saving power
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wakeReq <= 1'b0;
      end else begin
         wakeReq <= matchHit & (pstate_ff == i2pg_pkg::PS_SAVE);
      end
   end

endmodule : i2pg_regmap

// *** testbench/i2pg_regmap_sva.sv ***
`timescale 1ns/1ps
// ****************************************************************
// power gating and register bus checker
// ****************************************************************
module i2pg_regmap_sva (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic cpuIdle,
   input wire logic ctrlClkRun,
   input wire logic powerSave,
   input wire logic engineEnable,
   input wire logic wakeReq
);
   // one clock domain, so one clocking and one disable for all
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   // bus answers: exactly one cycle after take, one cycle long
   a_ack_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   a_ack_pulse: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   // upper half never implemented, idle bus reads zero
   a_upper_zero: assert property (
      wb_dat_o[31:16] == 16'h0000)
      else $error("upper read data not zero");
   // data is cleared on the first edge that sees the request gone
   a_idle_data: assert property (
      !wb_cyc_i && !wb_ack_o |=> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero outside a transfer");
   // a gated controller can neither run nor sit in save state
   a_gate_stops: assert property (
      !ctrlClkRun |-> !engineEnable && !powerSave)
      else $error("controller active while clock gated");
   a_save_engine: assert property (
      powerSave |-> !engineEnable)
      else $error("engine enabled in save state");
   // save state needs the cpu idle, allow up to a two-cycle lag
   a_run_when_busy: assert property (
      !cpuIdle && !$past(cpuIdle) && !$past(cpuIdle, 2) |-> !powerSave)
      else $error("save state without cpu idle");
   // wake only from save state, as a single pulse
   a_wake_save: assert property (
      wakeReq |-> powerSave || $past(powerSave))
      else $error("wake request outside save state");
   a_wake_pulse: assert property (
      wakeReq |=> !wakeReq)
      else $error("wake request longer than one cycle");
endmodule : i2pg_regmap_sva

// *** testbench/tb_i2c_power_gating_regmap.sv ***
`timescale 1ns/1ps
module tb_i2c_power_gating_regmap;
   logic core_clk = 1'h0;
   logic arst_n = 1'h0;
   logic wbCyc = 1'h0;
   logic wbStb = 1'h0;
   logic wbWe = 1'h0;
   logic [5:0] wbAdr = 6'h00;
   logic [31:0] wbDatI = 32'h0;
   logic [31:0] wbDatO;
   logic wbAck;
   logic cpuIdle = 1'h0;
   logic sclIn = 1'h1;
   logic sdaIn = 1'h1;
   logic ctrlClkRun, powerSave, engineEnable, wakeReq;
   logic [31:0] rd;
   int n_errors = 0;
   int total_checks = 0;
   int nWake = 0;
   // writable registers and the bits they implement
   logic [5:0] ofsRw [6] = '{i2pg_pkg::OFS_TRANSMIT_DATA,
      i2pg_pkg::OFS_BAUD_RELOAD, i2pg_pkg::OFS_CONTROL_MAIN,
      i2pg_pkg::OFS_OWN_ADDRESS, i2pg_pkg::OFS_ADDRESS_MASK,
      i2pg_pkg::OFS_CONTROL_HIGH};
   logic [15:0] mskRw [6] = '{16'h00FF, 16'h01FF, 16'hBFFF, 16'h03FF,
      16'h03FF, 16'h007F};

   always #50 core_clk = ~core_clk;

   i2pg_regmap dut_u (.core_clk(core_clk), .arst_n(arst_n),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(4'h3), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .cpuIdle(cpuIdle),
      .sclIn(sclIn), .sdaIn(sdaIn), .ctrlClkRun(ctrlClkRun),
      .powerSave(powerSave), .engineEnable(engineEnable),
      .wakeReq(wakeReq));

   // count wake pulses, a double pulse shows as two
   always @(posedge core_clk) begin
      if (wakeReq === 1'h1) begin
         nWake <= nWake + 1;
      end
   end

   // ****************************************************************
   // bus and pin tasks
   // ****************************************************************
   task automatic results();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick

   // classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic we, input logic [5:0] adr,
      input logic [15:0] d);
      logic got;
      got = 1'h0;
      @(posedge core_clk);
      wbCyc <= 1'h1;
      wbStb <= 1'h1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatI <= {16'h0000, d};
      for (int i = 0; i < 16 && !got; i++) begin
         @(posedge core_clk);
         got = (wbAck === 1'h1);
      end
      rd = wbDatO;
      wbCyc <= 1'h0;
      wbStb <= 1'h0;
      if (!got) begin
         n_errors++;
         $display("ERROR %0t: bus answer missing", $time);
         results();
      end
   endtask : wb

   task automatic rdchk(input logic [5:0] adr, input logic [15:0] exp);
      wb(1'h0, adr, 16'h0000);
      chk(rd, {16'h0000, exp});
   endtask : rdchk

   // slow pin phases so the two-flop synchronisers keep up
   task automatic pins(input logic c, input logic d);
      sclIn <= c;
      sdaIn <= d;
      tick(4);
   endtask : pins

   task automatic send_addr(input logic [7:0] b);
      pins(1'h1, 1'h0);
      pins(1'h0, 1'h0);
      for (int i = 7; i >= 0; i--) begin
         pins(1'h0, b[i]);
         pins(1'h1, b[i]);
         pins(1'h0, b[i]);
      end
      pins(1'h1, 1'h0);
      pins(1'h1, 1'h1);
   endtask : send_addr

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      tick(6);
      arst_n <= 1'h1;
      for (int i = 0; i < 10; i++) begin
         rdchk(6'(i * 4), 16'h0000);
      end
      rdchk(6'h28, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         wb(1'h1, ofsRw[i], 16'hFFFF);
         rdchk(ofsRw[i], mskRw[i]);
      end
      rdchk(i2pg_pkg::OFS_CONTROL_LOW, 16'hBFFF);
      wb(1'h1, i2pg_pkg::OFS_RECEIVE_DATA, 16'hFFFF);
      rdchk(i2pg_pkg::OFS_RECEIVE_DATA, 16'h0000);
      tick(2);
      chk({31'h0, engineEnable}, 32'h1);
      wb(1'h1, i2pg_pkg::OFS_OWN_ADDRESS, 16'h002A);
      wb(1'h1, i2pg_pkg::OFS_ADDRESS_MASK, 16'h0000);
      // idle with stop-in-idle set: save state, contents kept
      cpuIdle <= 1'h1;
      tick(3);
      chk({31'h0, powerSave}, 32'h1);
      chk({31'h0, engineEnable}, 32'h0);
      rdchk(i2pg_pkg::OFS_CONTROL_MAIN, 16'hBFFF);
      send_addr(8'h54);
      chk(nWake, 32'h1);
      rdchk(i2pg_pkg::OFS_BUS_STATUS, 16'h0012);
      rdchk(i2pg_pkg::OFS_RECEIVE_DATA, 16'h0054);
      cpuIdle <= 1'h0;
      tick(3);
      chk({31'h0, powerSave}, 32'h0);
      chk({31'h0, engineEnable}, 32'h1);
      // idle with stop-in-idle clear: keeps running
      wb(1'h1, i2pg_pkg::OFS_CONTROL_MAIN, 16'h8000);
      cpuIdle <= 1'h1;
      tick(3);
      chk({31'h0, powerSave}, 32'h0);
      chk({31'h0, engineEnable}, 32'h1);
      cpuIdle <= 1'h0;
      // module disable: gated, writes dropped, reads zero
      wb(1'h1, i2pg_pkg::OFS_PERIPH_DISABLE, 16'h0001);
      tick(2);
      chk({31'h0, ctrlClkRun}, 32'h0);
      chk({31'h0, engineEnable}, 32'h0);
      rdchk(i2pg_pkg::OFS_CONTROL_MAIN, 16'h0000);
      wb(1'h1, i2pg_pkg::OFS_CONTROL_MAIN, 16'h0000);
      rdchk(i2pg_pkg::OFS_PERIPH_DISABLE, 16'h0001);
      wb(1'h1, i2pg_pkg::OFS_PERIPH_DISABLE, 16'h0000);
      tick(2);
      chk({31'h0, ctrlClkRun}, 32'h1);
      rdchk(i2pg_pkg::OFS_CONTROL_MAIN, 16'h8000);
      // reset in mid-run restores everything
      arst_n <= 1'h0;
      tick(2);
      arst_n <= 1'h1;
      rdchk(i2pg_pkg::OFS_CONTROL_MAIN, 16'h0000);
      rdchk(i2pg_pkg::OFS_OWN_ADDRESS, 16'h0000);
      chk({31'h0, engineEnable}, 32'h0);
      results();
   end
endmodule : tb_i2c_power_gating_regmap

bind i2pg_regmap i2pg_regmap_sva sva_u (.core_clk(core_clk),
   .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpuIdle(cpuIdle),
   .ctrlClkRun(ctrlClkRun), .powerSave(powerSave),
   .engineEnable(engineEnable), .wakeReq(wakeReq));
